/* File: hw/port_wake_defs.vh */
// port_wake_defs.vh: offsets, field positions, reset values for the port
// input, wake and edge-select block.
// assumes it is included by bare name from the design files.
`ifndef PORT_WAKE_DEFS_VH
`define PORT_WAKE_DEFS_VH

// register offsets on the plain register port
`define OFS_PENDING            8'h05
`define OFS_TIMER_SOURCE       8'h06
`define OFS_EDGE_SELECT        8'h0C
`define OFS_PORT_A_ENABLE      8'h0D
`define OFS_PORT_B_ENABLE      8'h0E
`define OFS_PORT_A_DATA        8'h10

// edge select register fields
`define EDGE_PA0_LSB           0
`define EDGE_PB0_LSB           2
`define EDGE_TIMER_BIT         4

// edge select codes for the two pin fields
`define EDGE_BOTH              2'h0
`define EDGE_RISE              2'h1
`define EDGE_FALL              2'h2

// pending flag positions
`define PEND_PA0               0
`define PEND_PB0               1
`define PEND_TIMER             2

// timer source select: counter bit 8 plus field value
`define TIMER_BIT_BASE         4'h8

// reset values
`define EDGE_SELECT_RESET      5'h00
`define PORT_A_ENABLE_RESET    8'hFF
`define PORT_B_ENABLE_RESET    8'hEF
`define PORT_A_DATA_RESET      8'h00
`define TIMER_SOURCE_RESET     3'h0
`define PENDING_RESET          3'h0

`endif

/* File: hw/pin_sync_edge.v */
// pin_sync_edge.v: two-flop synchroniser with rise and fall detection.
// assumes pins are asynchronous to clk; one pulse per settled transition.
`timescale 1ns/1ps
`default_nettype none

module pin_sync_edge #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             ce,
  input  wire [WIDTH-1:0] pin,
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;
  reg [WIDTH-1:0] prev;

  // meta feeds only stable; edges come from stable against prev
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta   <= {WIDTH{1'b0}};
      stable <= {WIDTH{1'b0}};
      prev   <= {WIDTH{1'b0}};
    end else if (ce) begin
      meta   <= pin;
      stable <= meta;
      prev   <= stable;
    end
  end

  // one-cycle edge pulses, held off while frozen
  assign level = stable;
  assign rise  = {WIDTH{ce}} & stable & ~prev;
  assign fall  = {WIDTH{ce}} & ~stable & prev;

endmodule // pin_sync_edge

`default_nettype wire

/* File: hw/port_input_wake_edge_logic.v */
// port_input_wake_edge_logic.v: port A/B input enables, wake-up gating,
// pin and timer edge selection with sticky pending flags, port A data.
// assumes pins are asynchronous, timer count and register port are on clk.
//
// How it works
// - timer event on rising edge of selected bit when select is 0, falling when 1
// - pin edge fields: 00 both edges, 01 rising, 10 falling, 11 nothing
// - port A pins 7,6,4,3: enable gates digital input and wake-up together
// - port A pins 5 and 2: enable gates only the wake-up from toggling
// - port A bit 0 enable gates both wake-up and request from pin 0
// - port B bits 6..0 enable digital input; disabled pin cannot wake
// - emulator variant inverts the enable polarity of both enable registers
// - port A data register, eight bits, read and write, resets to zero
// - each edge event sets a sticky pending flag until software clears it
// - timer source is counter bit 8..15 chosen by a three-bit field
`include "port_wake_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module port_input_wake_edge_logic #(
  parameter EMULATOR_VARIANT = 0,
  parameter PORT_WIDTH       = 8
) (
  input  wire                  clk,
  input  wire                  reset_n,
  input  wire                  ce,
  input  wire [7:0]            addr,
  input  wire [7:0]            wdata,
  input  wire                  wr,
  input  wire                  rd,
  output reg  [7:0]            rdata,
  input  wire [PORT_WIDTH-1:0] port_a_pin,
  input  wire [PORT_WIDTH-1:0] port_b_pin,
  input  wire [15:0]           timer_count,
  output reg  [PORT_WIDTH-1:0] port_a_data,
  output reg  [PORT_WIDTH-1:0] port_a_digital_in,
  output reg  [PORT_WIDTH-1:0] port_b_digital_in,
  output wire [PORT_WIDTH-1:0] port_a_input_on,
  output wire [PORT_WIDTH-1:0] port_b_input_on,
  output reg                   wake_event,
  output wire [2:0]            pending
);

  // decode one 2-bit edge field against rise and fall pulses
  function edge_hit;
    input [1:0] sel;
    input       rise;
    input       fall;
    begin
      case (sel)
        `EDGE_BOTH: edge_hit = rise | fall;
        `EDGE_RISE: edge_hit = rise;
        `EDGE_FALL: edge_hit = fall;
        default:    edge_hit = 1'b0; // reserved code gives no event
      endcase
    end
  endfunction

  // write strobe for one register offset
  function reg_hit;
    input       strobe;
    input [7:0] where;
    input [7:0] offset;
    begin
      reg_hit = strobe & (where == offset);
    end
  endfunction

  // variant polarity: emulator parts treat a cleared bit as enabled
  function [7:0] eff_enable;
    input [7:0] value;
    begin
      if (EMULATOR_VARIANT != 0) begin
        eff_enable = ~value;
      end else begin
        eff_enable = value;
      end
    end
  endfunction

  // one-cycle pulse when a level is high now and was low before
  function pulse;
    input now_level;
    input old_level;
    input run;
    begin
      pulse = run & now_level & ~old_level;
    end
  endfunction

  // registers written by software, and the selected timer bit history
  reg  [4:0]            edge_select;
  reg  [7:0]            port_a_enable;
  reg  [7:0]            port_b_enable;
  reg  [2:0]            timer_source;
  reg  [2:0]            pending_flags;
  reg                   timer_bit_prev;

  // synchronised pin levels and edges
  wire [PORT_WIDTH-1:0] a_level;
  wire [PORT_WIDTH-1:0] a_rise;
  wire [PORT_WIDTH-1:0] a_fall;
  wire [PORT_WIDTH-1:0] b_level;
  wire [PORT_WIDTH-1:0] b_rise;
  wire [PORT_WIDTH-1:0] b_fall;

  // effective enables after the variant polarity
  wire [7:0]            a_en;
  wire [7:0]            b_en;
  wire [7:0]            a_wake_mask;
  wire [7:0]            b_wake_mask;
  wire [7:0]            a_input_mask;
  wire [7:0]            b_input_mask;

  // event strobes
  wire [3:0]            timer_index;
  wire                  timer_bit;
  wire                  timer_rise;
  wire                  timer_fall;
  wire                  hit_pa0;
  wire                  hit_pb0;
  wire                  hit_timer;
  wire [2:0]            hits;
  wire [1:0]            pa0_sel;
  wire [1:0]            pb0_sel;
  wire [PORT_WIDTH-1:0] a_toggle;
  wire [PORT_WIDTH-1:0] b_toggle;
  wire                  a_wake_hit;
  wire                  b_wake_hit;
  wire                  wake_hit;

  // register write decode
  wire                  wr_edge;
  wire                  wr_a_en;
  wire                  wr_b_en;
  wire                  wr_a_data;
  wire                  wr_timer;
  wire                  wr_pending;
  reg  [7:0]            read_value;
  reg  [2:0]            next_pending;
  reg  [7:0]            next_rdata;

  // pin synchronisers for both ports
  pin_sync_edge #(
    .WIDTH (PORT_WIDTH)
  ) u_sync_a (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .pin     (port_a_pin),
    .level   (a_level),
    .rise    (a_rise),
    .fall    (a_fall)
  );

  pin_sync_edge #(
    .WIDTH (PORT_WIDTH)
  ) u_sync_b (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .pin     (port_b_pin),
    .level   (b_level),
    .rise    (b_rise),
    .fall    (b_fall)
  );

  // emulator parts read the enable bits inverted
  assign a_en = eff_enable(port_a_enable);
  assign b_en = eff_enable(port_b_enable);

  // input gating: pins 7,6,4,3 follow their bit; 5,2,1,0 stay on
  assign a_input_mask = {a_en[7], a_en[6], 1'b1, a_en[4], a_en[3], 3'b111};
  // wake gating: every bit but reserved pin 1 gates its pin's wake
  assign a_wake_mask  = {a_en[7:2], 1'b1, a_en[0]};
  // port B: bits 6..0 gate input and wake; reserved bit 7 stays on
  assign b_input_mask = {1'b1, b_en[6:0]};
  assign b_wake_mask  = b_input_mask;

  // pad-level enables so analog and crystal pins can stop leakage
  assign port_a_input_on = a_input_mask[PORT_WIDTH-1:0];
  assign port_b_input_on = b_input_mask[PORT_WIDTH-1:0];

  // timer source: counter bit 8 plus the select field
  assign timer_index = `TIMER_BIT_BASE + {1'b0, timer_source};
  assign timer_bit   = timer_count[timer_index];
  assign timer_rise  = pulse(timer_bit, timer_bit_prev, ce);
  assign timer_fall  = pulse(timer_bit_prev, timer_bit, ce);

  // two-bit edge fields of the two pin sources
  assign pa0_sel   = edge_select[`EDGE_PA0_LSB +: 2];
  assign pb0_sel   = edge_select[`EDGE_PB0_LSB +: 2];

  // edge selection per source
  assign hit_pa0   = a_en[0] & edge_hit(pa0_sel, a_rise[0], a_fall[0]);
  assign hit_pb0   = b_en[0] & edge_hit(pb0_sel, b_rise[0], b_fall[0]);
  assign hit_timer = edge_select[`EDGE_TIMER_BIT] ? timer_fall : timer_rise;

  // event vector in pending flag order
  assign hits      = {hit_timer, hit_pb0, hit_pa0};

  // a toggle is either edge of a synchronised pin
  assign a_toggle   = a_rise | a_fall;
  assign b_toggle   = b_rise | b_fall;

  // any toggle on a wake-enabled pin wakes the system
  assign a_wake_hit = |(a_toggle & a_wake_mask[PORT_WIDTH-1:0]);
  assign b_wake_hit = |(b_toggle & b_wake_mask[PORT_WIDTH-1:0]);
  assign wake_hit   = a_wake_hit | b_wake_hit;

  // write strobes per register
  assign wr_edge    = reg_hit(wr, addr, `OFS_EDGE_SELECT);
  assign wr_a_en    = reg_hit(wr, addr, `OFS_PORT_A_ENABLE);
  assign wr_b_en    = reg_hit(wr, addr, `OFS_PORT_B_ENABLE);
  assign wr_a_data  = reg_hit(wr, addr, `OFS_PORT_A_DATA);
  assign wr_timer   = reg_hit(wr, addr, `OFS_TIMER_SOURCE);
  assign wr_pending = reg_hit(wr, addr, `OFS_PENDING);

  // pending flags: writing 0 clears a bit, a new event in the same cycle wins
  always @* begin
    next_pending = pending_flags;
    if (wr_pending) begin
      next_pending = pending_flags & wdata[2:0];
    end
    next_pending = next_pending | hits;
  end

  // edge select register, write-only
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_select <= `EDGE_SELECT_RESET;
    end else if (ce && wr_edge) begin
      edge_select <= wdata[4:0];
    end
  end

  // port A enable register, write-only
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_a_enable <= `PORT_A_ENABLE_RESET;
    end else if (ce && wr_a_en) begin
      port_a_enable <= wdata;
    end
  end

  // port B enable register, write-only
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_b_enable <= `PORT_B_ENABLE_RESET;
    end else if (ce && wr_b_en) begin
      port_b_enable <= wdata;
    end
  end

  // timer source select, write-only
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_source <= `TIMER_SOURCE_RESET;
    end else if (ce && wr_timer) begin
      timer_source <= wdata[2:0];
    end
  end

  // port A data register
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_a_data <= `PORT_A_DATA_RESET;
    end else if (ce && wr_a_data) begin
      port_a_data <= wdata[PORT_WIDTH-1:0];
    end
  end

  // sticky pending flags
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_flags <= `PENDING_RESET;
    end else if (ce) begin
      pending_flags <= next_pending;
    end
  end

  // selected timer bit history for edge detection
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_bit_prev <= 1'b0;
    end else if (ce) begin
      timer_bit_prev <= timer_bit;
    end
  end

  // gated digital inputs, registered
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port_a_digital_in <= {PORT_WIDTH{1'b0}};
      port_b_digital_in <= {PORT_WIDTH{1'b0}};
    end else if (ce) begin
      port_a_digital_in <= a_level & a_input_mask[PORT_WIDTH-1:0];
      port_b_digital_in <= b_level & b_input_mask[PORT_WIDTH-1:0];
    end
  end

  // wake pulse, one cycle per qualifying toggle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_event <= 1'b0;
    end else if (ce) begin
      wake_event <= wake_hit;
    end
  end

  // read mux: write-only registers read as zero
  always @* begin
    read_value = 8'h00;
    case (addr)
      `OFS_PORT_A_DATA:   read_value = port_a_data;
      `OFS_PENDING:       read_value = {5'h00, pending_flags};
      `OFS_EDGE_SELECT:   read_value = 8'h00; // write-only
      `OFS_PORT_A_ENABLE: read_value = 8'h00; // write-only
      `OFS_PORT_B_ENABLE: read_value = 8'h00; // write-only
      `OFS_TIMER_SOURCE:  read_value = 8'h00; // write-only
      default:            read_value = 8'h00;
    endcase
  end

  // read data is zero unless a read strobe is taken
  always @* begin
    next_rdata = 8'h00;
    if (rd) begin
      next_rdata = read_value;
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= next_rdata;
    end
  end

  assign pending = pending_flags;

endmodule // port_input_wake_edge_logic

`default_nettype wire

/* File: verif/port_wake_sva.sv */
// port_wake_sva.sv: assertions on the port block's top-level ports.
// assumes the write-only registers are rebuilt here from the bus writes.
`timescale 1ns/1ps
`default_nettype none
module port_wake_sva #(
  parameter EMULATOR_VARIANT = 0,
  parameter PORT_WIDTH       = 8
) (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  ce,
  input wire logic [7:0]            addr,
  input wire logic [7:0]            wdata,
  input wire logic                  wr,
  input wire logic                  rd,
  input wire logic [7:0]            rdata,
  input wire logic [15:0]           timer_count,
  input wire logic [PORT_WIDTH-1:0] port_a_data,
  input wire logic [PORT_WIDTH-1:0] port_a_input_on,
  input wire logic [PORT_WIDTH-1:0] port_b_input_on,
  input wire logic [2:0]            pending
);
  logic [7:0] esel;
  logic [7:0] a_en;
  logic [7:0] b_en;
  logic [2:0] tsrc;
  logic [2:0] keep;
  logic       tbit;
  logic [7:0] a_eff;
  logic [7:0] b_eff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // shadow copies of the write-only registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      esel <= 8'h00;
      a_en <= 8'hFF;
      b_en <= 8'hEF;
      tsrc <= 3'h0;
    end else if (ce && wr) begin
      if (addr == 8'h0C) esel <= wdata;
      if (addr == 8'h0D) a_en <= wdata;
      if (addr == 8'h0E) b_en <= wdata;
      if (addr == 8'h06) tsrc <= wdata[2:0];
    end
  end
  // flags kept by a pending write, selected timer bit
  assign keep = (wr && ce && addr == 8'h05) ? wdata[2:0] : 3'h7;
  assign tbit = timer_count[{1'b1, tsrc}];
  // enables as the build variant reads them
  assign a_eff = (EMULATOR_VARIANT != 0) ? ~a_en : a_en;
  assign b_eff = (EMULATOR_VARIANT != 0) ? ~b_en : b_en;
  sequence s_tedge; ce && (esel[4] ? $fell(tbit) : $rose(tbit)); endsequence
  sequence s_tset; ##[1:2] pending[2]; endsequence
  property p_a_on; port_a_input_on == (a_eff | 8'h27); endproperty
  property p_b_on; port_b_input_on == (b_eff | 8'h80); endproperty
  property p_wr; wr && ce && addr == 8'h10 |=> port_a_data == $past(wdata); endproperty
  property p_rd; rd && ce && addr == 8'h10 |=> rdata == $past(port_a_data); endproperty
  property p_keep; 1'b1 |=> ($past(pending & keep) & ~pending) == 3'h0; endproperty
  property p_timer; s_tedge |-> s_tset; endproperty
  property p_pa0; $rose(pending[0]) |-> esel[1:0] != 2'h3 && a_eff[0]; endproperty
  property p_pb0; $rose(pending[1]) |-> esel[3:2] != 2'h3 && b_eff[0]; endproperty
  a_a_on: assert property (p_a_on) else $error("port a input enable");
  a_b_on: assert property (p_b_on) else $error("port b input enable");
  a_wr: assert property (p_wr) else $error("data write");
  a_rd: assert property (p_rd) else $error("data read");
  a_keep: assert property (p_keep) else $error("flag lost");
  a_timer: assert property (p_timer) else $error("timer flag");
  a_pa0: assert property (p_pa0) else $error("pin a0 flag");
  a_pb0: assert property (p_pb0) else $error("pin b0 flag");
endmodule // port_wake_sva
bind port_input_wake_edge_logic port_wake_sva #(
  .EMULATOR_VARIANT(EMULATOR_VARIANT), .PORT_WIDTH(PORT_WIDTH)
) u_sva (
  .clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .timer_count(timer_count), .port_a_data(port_a_data),
  .port_a_input_on(port_a_input_on), .port_b_input_on(port_b_input_on), .pending(pending)
);
`default_nettype wire

/* File: verif/pin_far_side.sv */
// pin_far_side.sv: model of the external pins and the timer count.
// assumes levels change after a rising clk and then hold for six cycles.
`timescale 1ns/1ps
`default_nettype none
module pin_far_side (
  input  wire logic        clk,
  output var  logic [7:0]  port_a_pin,
  output var  logic [7:0]  port_b_pin,
  output var  logic [15:0] timer_count
);
  initial begin
    port_a_pin = 8'h00;
    port_b_pin = 8'h00;
    timer_count = 16'h0000;
  end
  // new levels land after an edge and settle through the synchroniser
  task automatic drive(input logic [7:0] a, input logic [7:0] b, input logic [15:0] t);
    @(posedge clk);
    port_a_pin <= a;
    port_b_pin <= b;
    timer_count <= t;
    repeat (6) @(posedge clk);
  endtask
endmodule // pin_far_side
`default_nettype wire

/* File: verif/test_port_input_wake_edge_logic.sv */
// test_port_input_wake_edge_logic.sv: self-checking bench for the port block.
// assumes the far-side model owns pins and timer, the bench owns the bus.
`timescale 1ns/1ps
`default_nettype none
module test_port_input_wake_edge_logic;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        ce = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata, pa_data, a_dig, b_dig, a_on, b_on, a_pin, b_pin, wakes, got;
  logic [15:0] tcount;
  logic [7:0]  e_a_on, e_b_on;
  logic [2:0]  pending;
  logic        wake_event;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cycles = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  port_input_wake_edge_logic DUT (
    .clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .port_a_pin(a_pin), .port_b_pin(b_pin), .timer_count(tcount),
    .port_a_data(pa_data), .port_a_digital_in(a_dig), .port_b_digital_in(b_dig),
    .port_a_input_on(a_on), .port_b_input_on(b_on), .wake_event(wake_event),
    .pending(pending)
  );
  pin_far_side far (.clk(clk), .port_a_pin(a_pin), .port_b_pin(b_pin), .timer_count(tcount));
  // emulator build on the same bus and pins, enables read inverted
  port_input_wake_edge_logic #(.EMULATOR_VARIANT(1)) dut_emu (
    .clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(), .port_a_pin(a_pin), .port_b_pin(b_pin), .timer_count(tcount),
    .port_a_data(), .port_a_digital_in(), .port_b_digital_in(),
    .port_a_input_on(e_a_on), .port_b_input_on(e_b_on), .wake_event(), .pending()
  );
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(string n, logic [7:0] s, logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    got = rdata;
  endtask
  // drive pins and count wake pulses meanwhile
  task automatic pins(logic [7:0] a, logic [7:0] b, logic [15:0] t);
    wakes = 8'h00;
    fork
      far.drive(a, b, t);
      repeat (7) @(negedge clk) wakes = wakes + {7'h00, wake_event};
    join
    @(negedge clk);
  endtask
  task automatic t_regs();
    @(negedge clk);
    check("data rst", pa_data, 8'h00);
    check("a on rst", a_on, 8'hFF);
    check("b on rst", b_on, 8'hEF);
    check("emu a rst", e_a_on, 8'h27);
    check("emu b rst", e_b_on, 8'h90);
    wr_reg(8'h10, 8'hA5);
    rd_reg(8'h10);
    check("data", got, 8'hA5);
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(8'h10, 8'h5A);
    ce <= 1'b1;
    rd_reg(8'h10);
    check("frozen", got, 8'hA5);
    rd_reg(8'h0C);
    check("wo read", got, 8'h00);
    rd_reg(8'h33);
    check("unmapped", got, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_edges();
    logic r, f;
    for (int c = 0; c < 4; c++) begin
      r = (c == 0 || c == 1);
      f = (c == 0 || c == 2);
      wr_reg(8'h0C, {4'h0, c[1:0], c[1:0]});
      pins(8'h01, 8'h01, 16'h0000);
      check("rise", {5'h00, pending}, {6'h00, r, r});
      check("wake", wakes, 8'h01);
      wr_reg(8'h05, 8'h00);
      @(negedge clk);
      check("cleared", {5'h00, pending}, 8'h00);
      pins(8'h00, 8'h00, 16'h0000);
      check("fall", {5'h00, pending}, {6'h00, f, f});
      wr_reg(8'h05, 8'h00);
    end
    $display("t_edges done");
  endtask
  task automatic t_gate();
    logic [7:0] ofs, dig, wk, m;
    wr_reg(8'h0C, 8'h00);
    for (int p = 0; p < 2; p++) begin
      ofs = p ? 8'h0E : 8'h0D;
      dig = p ? 8'h80 : 8'h27;
      wk = p ? 8'h80 : 8'h02;
      for (int b = 0; b < 8; b++) begin
        m = 8'h01 << b;
        wr_reg(ofs, 8'h00);
        pins(p ? 8'h00 : m, p ? m : 8'h00, 16'h0000);
        check("wake off", wakes, {7'h00, wk[b]});
        check("dig in", p ? b_dig : a_dig, dig & m);
        check("flag off", {5'h00, pending}, 8'h00);
        check("pad off", p ? b_on : a_on, dig);
        check("emu off", p ? e_b_on : e_a_on, 8'hFF);
        wr_reg(ofs, 8'hFF);
        pins(8'h00, 8'h00, 16'h0000);
        check("wake on", wakes, 8'h01);
        check("flag on", {5'h00, pending}, b == 0 ? (p ? 8'h02 : 8'h01) : 8'h00);
        check("pad on", p ? b_on : a_on, 8'hFF);
        check("emu on", p ? e_b_on : e_a_on, dig);
        wr_reg(8'h05, 8'h00);
      end
    end
    $display("t_gate done");
  endtask
  task automatic t_timer();
    for (int s = 0; s < 16; s++) begin
      wr_reg(8'h06, {5'h00, s[2:0]});
      wr_reg(8'h0C, {3'h0, s[3], 4'h0});
      pins(8'h00, 8'h00, 16'h0100 << s[2:0]);
      check("t rise", {5'h00, pending}, {5'h00, !s[3], 2'h0});
      wr_reg(8'h05, 8'h00);
      pins(8'h00, 8'h00, 16'h0000);
      check("t fall", {5'h00, pending}, {5'h00, s[3], 2'h0});
      wr_reg(8'h05, 8'h00);
    end
    $display("t_timer done");
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_edges();
    t_gate();
    t_timer();
    end_of_test();
  end
endmodule // test_port_input_wake_edge_logic
`default_nettype wire
